// ---- rtl/trs_top.sv ----
// Three timer register sets with external reset source selection over APB
`timescale 1ns/10ps
module trs_top (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer clock ticks, one per timer
   input wire logic [2:0] timer_tick,
   // Sources
   input wire logic timer_input_pin_mapping,
   input wire trs_pkg::trs_src_t src,
   input wire logic [2:0] postscaled,
   // Results
   output logic [2:0] ext_reset,
   output logic [23:0] count_out
);
   import trs_pkg::*;

   logic [7:0] period_ff [NUM_TIMERS];
   logic [7:0] ctrl_ff [NUM_TIMERS];
   logic [7:0] clksel_ff [NUM_TIMERS];
   logic [7:0] rstsel_ff [NUM_TIMERS];
   logic [7:0] hwlim_ff [NUM_TIMERS];
   logic [7:0] nxt_period [NUM_TIMERS];
   logic [7:0] nxt_ctrl [NUM_TIMERS];
   logic [7:0] nxt_clksel [NUM_TIMERS];
   logic [7:0] nxt_rstsel [NUM_TIMERS];
   logic [7:0] nxt_hwlim [NUM_TIMERS];
   logic [7:0] cnt_v [NUM_TIMERS];
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic slverr_c;
   logic wr_en;
   logic rd_en;
   logic [1:0] tsel;
   logic [4:0] rofs;
   logic hit;

   // Address split: timer slot and register offset in it
   assign tsel = paddr[6:5];
   assign rofs = paddr[4:0];
   assign hit = (paddr[11:7] == 5'h00) && (tsel < 2'h3) && (paddr[1:0] == 2'h0)
      && (rofs <= OFS_HWLIMIT) && (rofs[1:0] == 2'h0);
   assign wr_en = psel && penable && pwrite && hit;
   assign rd_en = psel && !penable && !pwrite && hit;
   // Zero wait states keep the master simple
   assign pready = 1'b1;
   assign slverr_c = psel && penable && !hit;
   assign pslverr = slverr_c;

   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
         logic sel_me;
         assign sel_me = wr_en && (tsel == 2'(g));

         // Register write decode for this timer
         always_comb begin
            nxt_period[g] = period_ff[g];
            nxt_ctrl[g] = ctrl_ff[g];
            nxt_clksel[g] = clksel_ff[g];
            nxt_rstsel[g] = rstsel_ff[g];
            nxt_hwlim[g] = hwlim_ff[g];
            if (sel_me) begin
               case (rofs)
                  OFS_PERIOD: nxt_period[g] = pwdata[7:0]; // RULE_05
                  OFS_CTRL: nxt_ctrl[g] = pwdata[7:0];
                  OFS_CLKSEL: nxt_clksel[g] = pwdata[7:0] & SEL_MASK;
                  OFS_RSTSEL: nxt_rstsel[g] = pwdata[7:0] & SEL_MASK; // RULE_01
                  OFS_HWLIMIT: nxt_hwlim[g] = pwdata[7:0];
                  default: nxt_period[g] = period_ff[g];
               endcase
            end
         end

         // Every reset clears the select field
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               period_ff[g] <= PERIOD_RESET;
               ctrl_ff[g] <= REG_RESET;
               clksel_ff[g] <= REG_RESET;
               rstsel_ff[g] <= REG_RESET; // RULE_02
               hwlim_ff[g] <= REG_RESET;
            end else begin
               period_ff[g] <= nxt_period[g];
               ctrl_ff[g] <= nxt_ctrl[g];
               clksel_ff[g] <= nxt_clksel[g];
               rstsel_ff[g] <= nxt_rstsel[g];
               hwlim_ff[g] <= nxt_hwlim[g];
            end
         end

         trs_mux #(.SELF(g)) u_mux (
            .reset_source_code(rstsel_ff[g][SEL_W-1:0]),
            .postscaled(postscaled),
            .timer_input_pin_mapping(timer_input_pin_mapping),
            .src(src),
            .ext_reset(ext_reset[g])
         );

         // Counter runs while the on bit (bit 7) of control is set
         trs_cnt u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .tick(timer_tick[g]),
            .run(ctrl_ff[g][7]),
            .ext_reset(ext_reset[g]),
            .wr_count(sel_me && rofs == OFS_COUNT),
            .wr_data(pwdata[7:0]),
            .period_value(period_ff[g]),
            .count_value(cnt_v[g])
         );
         assign count_out[g*8 +: 8] = cnt_v[g];
      end
   endgenerate

   // Read data captured in setup phase, held through access
   always_comb begin
      nxt_prdata = prdata_ff;
      if (rd_en) begin
         nxt_prdata = 32'h00000000;
         case (rofs)
            OFS_COUNT: nxt_prdata[7:0] = cnt_v[tsel];
            OFS_PERIOD: nxt_prdata[7:0] = period_ff[tsel];
            OFS_CTRL: nxt_prdata[7:0] = ctrl_ff[tsel];
            OFS_CLKSEL: nxt_prdata[7:0] = clksel_ff[tsel];
            OFS_RSTSEL: nxt_prdata[7:0] = rstsel_ff[tsel] & SEL_MASK; // RULE_01
            OFS_HWLIMIT: nxt_prdata[7:0] = hwlim_ff[tsel];
            default: nxt_prdata = 32'h00000000;
         endcase
      end else if (psel && !penable) begin
         nxt_prdata = 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;
endmodule : trs_top

// ---- pkg/trs_pkg.sv ----
// Package: constants, register map and carriers for the timer reset-source selector
//
// Behaviour
// RULE_01: Upper four bits of reset-select register read zero, writes there ignored.
// RULE_02: Four-bit select field in low bits, read/write, clears on every reset.
// RULE_03: Code zero routes the mapped timer input pin to the reset input.
// RULE_04: Codes 1-14 pick comparators, captures, other timers, zero-cross, cells, pulse gens.
// RULE_05: Each timer has readable/writable 8-bit count and period registers.
// RULE_06: Count equal to period clears the count on the next timer clock.
// RULE_07: Reserved select codes give an inactive reset input.
package trs_pkg;
   localparam int NUM_TIMERS = 3;
   localparam int SEL_W = 4;
   localparam int REG_W = 8;
   localparam int SRC_W = 16;
   // Per-timer window of six registers, timers spaced by this stride
   localparam logic [11:0] TIMER_STRIDE = 12'h020;
   localparam logic [4:0] OFS_COUNT = 5'h00;
   localparam logic [4:0] OFS_PERIOD = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_CLKSEL = 5'h0c;
   localparam logic [4:0] OFS_RSTSEL = 5'h10;
   localparam logic [4:0] OFS_HWLIMIT = 5'h14;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [7:0] SEL_MASK = 8'h0f;
   // Select codes
   localparam logic [3:0] CODE_PIN = 4'h0;
   localparam logic [3:0] CODE_RESERVED = 4'hf;
   localparam logic [3:0] CODE_POST_FIRST = 4'h5;

   // External sources shared by all three timers
   typedef struct packed {
      logic comparator_one_synced;
      logic comparator_two_synced;
      logic capture_unit_one_output;
      logic capture_unit_two_output;
      logic zero_cross_output;
      logic logic_cell_one_output;
      logic logic_cell_two_output;
      logic logic_cell_three_output;
      logic logic_cell_four_output;
      logic pulse_gen_three_output;
      logic pulse_gen_four_output;
   } trs_src_t;

   // APB request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } trs_apb_req_t;
endpackage : trs_pkg

// ---- rtl/trs_mux.sv ----
// Reset-source multiplexer for one timer instance
`timescale 1ns/10ps
module trs_mux #(
   parameter int SELF = 0
) (
   // Selection
   input wire logic [3:0] reset_source_code,
   input wire logic [2:0] postscaled,
   // Sources
   input wire logic timer_input_pin_mapping,
   input wire trs_pkg::trs_src_t src,
   // Result
   output logic ext_reset
);
   import trs_pkg::*;

   logic [SRC_W-1:0] table_v;

   // Source table; own postscaled slot and code 15 are forced low
   always_comb begin
      table_v = '0;
      table_v[0] = timer_input_pin_mapping; // RULE_03
      table_v[1] = src.comparator_one_synced; // RULE_04
      table_v[2] = src.comparator_two_synced;
      table_v[3] = src.capture_unit_one_output;
      table_v[4] = src.capture_unit_two_output;
      table_v[5] = postscaled[0];
      table_v[6] = postscaled[1];
      table_v[7] = postscaled[2];
      table_v[8] = src.zero_cross_output;
      table_v[9] = src.logic_cell_one_output;
      table_v[10] = src.logic_cell_two_output;
      table_v[11] = src.logic_cell_three_output;
      table_v[12] = src.logic_cell_four_output;
      table_v[13] = src.pulse_gen_three_output;
      table_v[14] = src.pulse_gen_four_output;
      table_v[int'(CODE_POST_FIRST) + SELF] = 1'b0; // RULE_07
      table_v[CODE_RESERVED] = 1'b0; // RULE_07
      ext_reset = table_v[reset_source_code];
   end
endmodule : trs_mux

// ---- rtl/trs_cnt.sv ----
// Eight-bit count with period match for one timer instance
`timescale 1ns/10ps
module trs_cnt (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic tick,
   input wire logic run,
   input wire logic ext_reset,
   input wire logic wr_count,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] period_value,
   // State
   output logic [7:0] count_value
);
   import trs_pkg::*;

   logic [7:0] count_ff;
   logic [7:0] nxt_count;

   // Software write first, then reset input, then match, then increment
   always_comb begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = wr_data; // RULE_05
      end else if (ext_reset) begin
         nxt_count = REG_RESET;
      end else if (tick && count_ff == period_value) begin
         nxt_count = REG_RESET; // RULE_06
      end else if (tick && run) begin
         nxt_count = count_ff + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= REG_RESET;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count_value = count_ff;
endmodule : trs_cnt

// ---- dv/trs_chk.sv ----
// Port checker for the timer reset-source selector
`timescale 1ns/10ps
module trs_chk (
   // Bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Timer side
   input wire logic timer_input_pin_mapping,
   input wire logic [2:0] ext_reset,
   input wire logic [23:0] count_out
);
   logic acc;
   logic ok;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase and decoded register window
   assign acc = psel && penable;
   assign ok = paddr < 12'h060 && paddr[4:0] <= 5'h14 && paddr[1:0] == 2'h0;
   a_upper_zero: assert property (acc && !pwrite && paddr[4:0] == 5'h10 |-> prdata[31:4] == 28'h0)
      else $error("select read upper bits set");
   a_reset_pin: assert property ($rose(presetn) |-> ext_reset == {3{timer_input_pin_mapping}})
      else $error("reset select not pin after reset");
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low");
   a_bad_addr: assert property (acc && !ok |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_good_addr: assert property (acc && ok |-> !pslverr)
      else $error("mapped access refused");
   a_write_zero: assert property (acc && pwrite |-> prdata == 32'h0)
      else $error("read data during write");
   a_read_byte: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data above byte");
   a_ext_hold: assert property (ext_reset[0] && !(acc && pwrite && paddr == 12'h000)
      |=> count_out[7:0] == 8'h00)
      else $error("count not held by reset input");
endmodule : trs_chk
bind trs_top trs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .timer_input_pin_mapping, .ext_reset, .count_out);

// ---- dv/testbench.sv ----
// Register and routing tests for the timer reset-source selector
`timescale 1ns/10ps
module testbench;
   import trs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er;
   logic [2:0] timer_tick = 3'h0, ext_reset;
   logic [15:0] v = 16'h0;
   logic [23:0] count_out;
   trs_src_t src;
   int err_count = 0, comparisons = 0;
   // Source vector indexed by select code
   assign src = {v[1], v[2], v[3], v[4], v[8], v[9], v[10], v[11], v[12], v[13], v[14]};
   trs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_tick(timer_tick), .timer_input_pin_mapping(v[0]), .src(src),
      .postscaled(v[7:5]), .ext_reset(ext_reset), .count_out(count_out));
   // Free-running bus clock
   initial forever #20 pclk = ~pclk;
   function automatic logic [11:0] ra(input int g, input logic [4:0] o);
      return 12'(g) * TIMER_STRIDE + {7'h0, o};
   endfunction : ra
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         timer_tick <= 3'h1;
         @(posedge pclk);
         timer_tick <= 3'h0;
      end
   endtask : tick
   task automatic end_sim();
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #400000;
      err_count++;
      end_sim();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int g = 0; g < 3; g++) begin
         apb(1'b0, ra(g, OFS_RSTSEL), 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, ra(g, OFS_RSTSEL), 32'hff);
         apb(1'b0, ra(g, OFS_RSTSEL), 32'h0);
         chk(rd, 32'h0f);
         for (int c = 0; c < 16; c++) begin
            apb(1'b1, ra(g, OFS_RSTSEL), 32'(c));
            for (int k = 0; k < 2; k++) begin
               @(posedge pclk);
               v <= (k == 1) ? ~(16'h1 << c) : 16'h1 << c;
               @(negedge pclk);
               chk(ext_reset[g], k == 0 && c != 15 && c != 5 + g);
            end
         end
      end
      // Wrap at period with the reset input parked on a reserved code
      @(posedge pclk);
      v <= 16'h0;
      apb(1'b1, ra(0, OFS_RSTSEL), 32'hf);
      apb(1'b1, ra(0, OFS_PERIOD), 32'h3);
      apb(1'b1, ra(0, OFS_CTRL), 32'h80);
      tick(3);
      @(negedge pclk);
      chk(count_out[7:0], 32'h3);
      tick(1);
      @(negedge pclk);
      chk(count_out[7:0], 32'h0);
      apb(1'b0, ra(0, OFS_PERIOD), 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, ra(0, OFS_COUNT), 32'h2);
      apb(1'b0, ra(0, OFS_COUNT), 32'h0);
      chk(rd, 32'h2);
      // Pin code with pin high holds the count at zero
      @(posedge pclk);
      v <= 16'h1;
      apb(1'b1, ra(0, OFS_RSTSEL), 32'h0);
      tick(2);
      @(negedge pclk);
      chk(count_out[7:0], 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk({rd[31:1], er}, 32'h1);
      end_sim();
   end
endmodule : testbench
